// ### gil_pkg.sv
// Constants and carrier types for the terminal and legacy IRQ pin routing
package gil_pkg;

   // ----------------------------------------------------------------
   // Register map (configuration byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTL_OFFSET = 8'h8b;
   localparam logic [7:0] ROUTE_OFFSET = 8'h8c;
   localparam logic [5:0] CTL_DWORD = 6'h22;
   localparam logic [5:0] ROUTE_DWORD = 6'h23;
   localparam int CTL_LANE = 3;

   // ----------------------------------------------------------------
   // Terminal control fields and reset values
   // ----------------------------------------------------------------
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam int FLAG_BIT = 3;
   localparam int DOUT_BIT = 1;
   localparam int DIN_BIT = 0;
   localparam logic [7:0] CTL_RESET = 8'h80;
   localparam logic [1:0] MODE_RESET = 2'h2;
   localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Routing fields
   // ----------------------------------------------------------------
   localparam int PIN7_LO = 28;
   localparam int PIN6_LO = 24;
   localparam logic [3:0] CODE_SECONDARY = 4'h0;
   localparam logic [3:0] CODE_DMA_REQ = 4'h1;
   localparam logic [3:0] PIN7_FIRST_IRQ = 4'h2;
   localparam logic [3:0] PIN6_FIRST_IRQ = 4'h1;
   localparam logic DMA_GRANT_IDLE = 1'h1;

   // Terminal mode encodings
   typedef enum logic [1:0]
   {
      MODE_INTA = 2'h0,
      MODE_RSVD = 2'h1,
      MODE_INPUT = 2'h2,
      MODE_OUTPUT = 2'h3
   } gil_mode_t;

   // Configuration access request
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic func;
      logic [5:0] dword;
      logic [3:0] be;
      logic [31:0] wdata;
   } gil_cfg_req_t;

   // Configuration read answer
   typedef struct packed
   {
      logic valid;
      logic [31:0] data;
   } gil_cfg_rsp_t;

endpackage

// ### gil_mux_pin.sv
// One legacy IRQ mux pin: IRQ level or secondary function, registered
`timescale 1ns/1ns
module gil_mux_pin
#(
   parameter logic [3:0] FIRST_IRQ = 4'h1
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Selection
   input wire logic [3:0] code,
   input wire logic parallelIrq,
   input wire logic [15:0] irqLines,
   // Secondary function drive
   input wire logic altOut,
   input wire logic altOeN,
   // Pin drive
   output logic pinOut,
   output logic pinOeN
);

   logic pinOut_r;
   logic pinOut_nxt;
   logic pinOeN_r;
   logic pinOeN_nxt;

   // Pick the IRQ level or the secondary drive
   always_comb
   begin
      pinOut_nxt = altOut;
      pinOeN_nxt = altOeN;
      if (code >= FIRST_IRQ)
      begin
         pinOut_nxt = irqLines[code];
         pinOeN_nxt = ~parallelIrq;
      end
   end

   // Register the pin drive
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         pinOut_r <= 1'h0;
         pinOeN_r <= 1'h1;
      end
      else
      begin
         pinOut_r <= pinOut_nxt;
         pinOeN_r <= pinOeN_nxt;
      end
   end

   assign pinOut = pinOut_r;
   assign pinOeN = pinOeN_r;

endmodule

// ### gil_pin_routing.sv
// General pin three control and upper legacy IRQ mux pin routing
`timescale 1ns/1ns
module gil_pin_routing
(
   // Clock and global reset
   input wire logic clock,
   input wire logic rstn,
   // Configuration access
   input wire gil_pkg::gil_cfg_req_t cfgReq,
   output gil_pkg::gil_cfg_rsp_t cfgRsp,
   // Internal sources
   input wire logic intaReq,
   input wire logic [15:0] irqLines,
   input wire logic parallelIrq,
   input wire logic dmaEnable,
   input wire logic dmaRequest,
   input wire logic eepromSclOut,
   input wire logic eepromSclOeN,
   input wire logic eepromSdaOut,
   input wire logic eepromSdaOeN,
   // Internal sinks
   output logic dmaGrant,
   output logic eepromSdaIn,
   output logic eepromBlocked,
   // General pin three
   input wire logic gpioIn,
   output logic gpioOut,
   output logic gpioOeN,
   // Mux pin 7
   input wire logic pin7In,
   output logic pin7Out,
   output logic pin7OeN,
   // Mux pin 6
   input wire logic pin6In,
   output logic pin6Out,
   output logic pin6OeN
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   gil_pkg::gil_mode_t mode_r, mode_nxt;
   logic flag_r, flag_nxt;
   logic dout_r, dout_nxt;
   logic din_r, din_nxt;
   logic gpioOut_r, gpioOut_nxt;
   logic gpioOeN_r, gpioOeN_nxt;
   logic [31:0] route_r, route_nxt;
   gil_pkg::gil_cfg_rsp_t rsp_r, rsp_nxt;
   logic dmaGrant_r, dmaGrant_nxt;
   logic sdaIn_r, sdaIn_nxt;
   logic blocked_r, blocked_nxt;
   logic ctlWr, routeHit;
   logic [7:0] wrByte;
   logic inChange;
   logic [7:0] ctlByte;
   logic [3:0] code7, code6;
   logic dma7, dma6;
   logic alt7Out, alt7OeN, alt6Out, alt6OeN;

   // ----------------------------------------------------------------
   // Terminal control register
   // ----------------------------------------------------------------

   // Decode a write to the control byte; either function hits it
   assign ctlWr = cfgReq.wr && cfgReq.dword == gil_pkg::CTL_DWORD
      && cfgReq.be[gil_pkg::CTL_LANE];
   assign wrByte = cfgReq.wdata[31:24];
   assign inChange = mode_r == gil_pkg::MODE_INPUT
      && gpioIn != din_r;

   // Next values for mode, change flag, output bit and sampled input
   always_comb
   begin
      mode_nxt = mode_r;
      dout_nxt = dout_r;
      din_nxt = gpioIn;
      flag_nxt = flag_r;
      if (ctlWr)
      begin
         mode_nxt = gil_pkg::gil_mode_t'(
            wrByte[gil_pkg::MODE_HI:gil_pkg::MODE_LO]);
         dout_nxt = wrByte[gil_pkg::DOUT_BIT];
         if (wrByte[gil_pkg::FLAG_BIT])
         begin
            flag_nxt = 1'h0;
         end
      end
      if (inChange)
      begin
         flag_nxt = 1'h1;
      end
   end

   // Terminal drive per mode; INTA is open drain, active low
   always_comb
   begin
      gpioOut_nxt = 1'h0;
      gpioOeN_nxt = 1'h1;
      case (mode_r)
         gil_pkg::MODE_INTA:
         begin
            gpioOeN_nxt = ~intaReq;
         end
         gil_pkg::MODE_OUTPUT:
         begin
            gpioOut_nxt = dout_r;
            gpioOeN_nxt = 1'h0;
         end
         default: gpioOeN_nxt = 1'h1;
      endcase
   end

   // Readback byte with reserved bits as zero
   assign ctlByte = {mode_r, 2'h0, flag_r, 1'h0, dout_r, din_r};

   // Control state registers, cleared by global reset only
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         mode_r <= gil_pkg::gil_mode_t'(gil_pkg::MODE_RESET);
         flag_r <= 1'h0;
         dout_r <= 1'h0;
         din_r <= 1'h0;
         gpioOut_r <= 1'h0;
         gpioOeN_r <= 1'h1;
      end
      else
      begin
         mode_r <= mode_nxt;
         flag_r <= flag_nxt;
         dout_r <= dout_nxt;
         din_r <= din_nxt;
         gpioOut_r <= gpioOut_nxt;
         gpioOeN_r <= gpioOeN_nxt;
      end
   end

   assign gpioOut = gpioOut_r;
   assign gpioOeN = gpioOeN_r;

   // ----------------------------------------------------------------
   // Routing register and read path
   // ----------------------------------------------------------------
   assign routeHit = cfgReq.wr && cfgReq.dword == gil_pkg::ROUTE_DWORD;

   // Byte-lane writes to the routing register
   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_lane
         always_comb
         begin
            route_nxt[8*i +: 8] = route_r[8*i +: 8];
            if (routeHit && cfgReq.be[i])
            begin
               route_nxt[8*i +: 8] = cfgReq.wdata[8*i +: 8];
            end
         end
      end
   endgenerate

   // Read answer one cycle after the read strobe; unmapped reads zero
   always_comb
   begin
      rsp_nxt.valid = cfgReq.rd;
      rsp_nxt.data = 32'h0000_0000;
      if (cfgReq.rd && cfgReq.dword == gil_pkg::CTL_DWORD)
      begin
         rsp_nxt.data = {ctlByte, 24'h00_0000};
      end
      else if (cfgReq.rd && cfgReq.dword == gil_pkg::ROUTE_DWORD)
      begin
         rsp_nxt.data = route_r;
      end
   end

   // ----------------------------------------------------------------
   // Mux pin secondary functions
   // ----------------------------------------------------------------
   assign code7 = route_r[gil_pkg::PIN7_LO +: 4];
   assign code6 = route_r[gil_pkg::PIN6_LO +: 4];
   assign dma7 = code7 == gil_pkg::CODE_DMA_REQ
      || (code7 == gil_pkg::CODE_SECONDARY && dmaEnable);
   assign dma6 = code6 == gil_pkg::CODE_SECONDARY && dmaEnable;

   // Pin 7 carries DMA request or EEPROM clock; pin 6 grant or data
   always_comb
   begin
      alt7Out = eepromSclOut;
      alt7OeN = eepromSclOeN;
      if (dma7)
      begin
         alt7Out = dmaRequest;
         alt7OeN = 1'h0;
      end
      alt6Out = eepromSdaOut;
      alt6OeN = eepromSdaOeN;
      if (dma6)
      begin
         alt6Out = 1'h0;
         alt6OeN = 1'h1;
      end
   end

   // Grant, EEPROM data return and EEPROM lockout
   always_comb
   begin
      dmaGrant_nxt = dma6 ? pin6In : gil_pkg::DMA_GRANT_IDLE;
      sdaIn_nxt = (code6 == gil_pkg::CODE_SECONDARY && !dma6)
         ? pin6In : 1'h1;
      blocked_nxt = dma7 || dma6;
   end

   // Routing register and answer registers
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         route_r <= gil_pkg::ROUTE_RESET;
         rsp_r <= '0;
         dmaGrant_r <= gil_pkg::DMA_GRANT_IDLE;
         sdaIn_r <= 1'h1;
         blocked_r <= 1'h0;
      end
      else
      begin
         route_r <= route_nxt;
         rsp_r <= rsp_nxt;
         dmaGrant_r <= dmaGrant_nxt;
         sdaIn_r <= sdaIn_nxt;
         blocked_r <= blocked_nxt;
      end
   end

   assign cfgRsp = rsp_r;
   assign dmaGrant = dmaGrant_r;
   assign eepromSdaIn = sdaIn_r;
   assign eepromBlocked = blocked_r;

   // Mux pin 7 (IRQ2 and up)
   gil_mux_pin #(.FIRST_IRQ(gil_pkg::PIN7_FIRST_IRQ)) u_pin7
   (
      .clock(clock),
      .rstn(rstn),
      .code(code7),
      .parallelIrq(parallelIrq),
      .irqLines(irqLines),
      .altOut(alt7Out),
      .altOeN(alt7OeN),
      .pinOut(pin7Out),
      .pinOeN(pin7OeN)
   );

   // Mux pin 6 (IRQ1 and up)
   gil_mux_pin #(.FIRST_IRQ(gil_pkg::PIN6_FIRST_IRQ)) u_pin6
   (
      .clock(clock),
      .rstn(rstn),
      .code(code6),
      .parallelIrq(parallelIrq),
      .irqLines(irqLines),
      .altOut(alt6Out),
      .altOeN(alt6OeN),
      .pinOut(pin6Out),
      .pinOeN(pin6OeN)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_reset_ctl_value: assert property (disable iff (1'b0)
      !rstn |=> ctlByte == gil_pkg::CTL_RESET && route_r == 32'h0)
      else $error("Registers not at reset values after reset");
   a_flag_set_change: assert property (
      inChange |=> flag_r)
      else $error("Change flag not set on input change");
   a_flag_clear_one: assert property (
      ctlWr && wrByte[gil_pkg::FLAG_BIT] && !inChange |=> !flag_r)
      else $error("Change flag not cleared by writing one");
   a_flag_hold_zero: assert property (
      flag_r && !(ctlWr && wrByte[gil_pkg::FLAG_BIT]) |=> flag_r)
      else $error("Change flag lost without a clearing write");
   a_output_mode_drive: assert property (
      mode_r == gil_pkg::MODE_OUTPUT |=> !gpioOeN
      && gpioOut == $past(dout_r))
      else $error("Output mode does not drive the output bit");
   a_inta_open_drain: assert property (
      mode_r == gil_pkg::MODE_INTA |=> gpioOeN == !$past(intaReq)
      && !gpioOut)
      else $error("INTA mode drive wrong");
   a_input_level_read: assert property (
      cfgReq.rd && cfgReq.dword == gil_pkg::CTL_DWORD |=> cfgRsp.valid
      && cfgRsp.data[24] == $past(din_r) && cfgRsp.data[29:28] == 2'h0
      && !cfgRsp.data[26])
      else $error("Control readback wrong");
   a_route_write_all: assert property (
      routeHit && cfgReq.be == 4'hf |=> route_r == $past(cfgReq.wdata))
      else $error("Routing register write lost");
   a_pin7_dma_req: assert property (
      dma7 |=> !pin7OeN && pin7Out == $past(dmaRequest))
      else $error("Pin 7 does not carry DMA request");
   a_pin6_irq_level: assert property (
      parallelIrq && code6 != 4'h0 |=> !pin6OeN
      && pin6Out == $past(irqLines[code6]))
      else $error("Pin 6 does not carry routed IRQ level");

   c_flag_set: cover property (inChange ##1 flag_r);
   c_output_mode: cover property (mode_r == gil_pkg::MODE_OUTPUT);
   c_pin7_irq: cover property (parallelIrq && code7 >= 4'h2);
   c_dma_both: cover property (dma7 && dma6);

endmodule

// ### gil_far_side.sv
// Far side model: terminal driver, DMA host grant and EEPROM data line
`timescale 1ns/1ns
module gil_far_side
(
   // Commanded levels
   input wire logic extLevel,
   input wire logic hostLevel,
   // Device drive
   input wire logic gpioOut,
   input wire logic gpioOeN,
   input wire logic pin6Out,
   input wire logic pin6OeN,
   // Resolved wires
   output logic gpioIn,
   output logic pin6In
);
   // Terminal level: device drive wins, else the outside driver
   assign gpioIn = !gpioOeN ? gpioOut : extLevel;
   // Pin 6: grant from DMA host or EEPROM data when device releases it
   assign pin6In = !pin6OeN ? pin6Out : hostLevel;
endmodule

// ### gil_pin_routing_tb.sv
// Testbench for general pin three control and upper mux pin routing
`timescale 1ns/1ns
module gil_pin_routing_tb;
   logic clock = 0, rstn = 0, intaReq = 0, parallelIrq = 0;
   logic dmaEnable = 0, dmaRequest = 0, extLevel = 0, hostLevel = 1;
   logic eSclOut = 0, eSclOeN = 1, eSdaOut = 0, eSdaOeN = 1;
   logic [15:0] irqLines = 16'h0000;
   gil_pkg::gil_cfg_req_t req = '0;
   gil_pkg::gil_cfg_rsp_t rsp;
   logic dmaGrant, eSdaIn, eBlocked, gpioIn, gpioOut, gpioOeN;
   logic pin7Out, pin7OeN, pin6In, pin6Out, pin6OeN;
   logic [31:0] rd;
   int failures = 0, compares = 0, cycles = 0;

   // ----------------------------------------------------------------
   // Clock, design and far side
   // ----------------------------------------------------------------
   always #2 clock = ~clock;
   gil_pin_routing DUT (.clock(clock), .rstn(rstn), .cfgReq(req),
      .cfgRsp(rsp), .intaReq(intaReq), .irqLines(irqLines),
      .parallelIrq(parallelIrq), .dmaEnable(dmaEnable),
      .dmaRequest(dmaRequest), .eepromSclOut(eSclOut),
      .eepromSclOeN(eSclOeN), .eepromSdaOut(eSdaOut),
      .eepromSdaOeN(eSdaOeN), .dmaGrant(dmaGrant), .eepromSdaIn(eSdaIn),
      .eepromBlocked(eBlocked), .gpioIn(gpioIn), .gpioOut(gpioOut),
      .gpioOeN(gpioOeN), .pin7In(1'b0), .pin7Out(pin7Out),
      .pin7OeN(pin7OeN), .pin6In(pin6In), .pin6Out(pin6Out),
      .pin6OeN(pin6OeN));
   gil_far_side farSide (.extLevel(extLevel), .hostLevel(hostLevel),
      .gpioOut(gpioOut), .gpioOeN(gpioOeN), .pin6Out(pin6Out),
      .pin6OeN(pin6OeN), .gpioIn(gpioIn), .pin6In(pin6In));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task check(input string name, input logic [31:0] exp,
      input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Write through function 0 only
   task cfgWrite(input logic [5:0] dw, input logic [3:0] be,
      input logic [31:0] d);
      tick(1);
      req.wr = 1;
      req.func = 0;
      req.dword = dw;
      req.be = be;
      req.wdata = d;
      tick(1);
      req.wr = 0;
   endtask

   // Read: answer is valid just after the taking edge
   task cfgRead(input logic [5:0] dw, output logic [31:0] d);
      tick(1);
      req.rd = 1;
      req.func = 0;
      req.dword = dw;
      req.be = 4'hf;
      tick(1);
      req.rd = 0;
      check("rsp.valid", 1, rsp.valid);
      d = rsp.data;
   endtask

   task ctlRead(input logic [7:0] exp);
      cfgRead(gil_pkg::CTL_DWORD, rd);
      check("control", exp, rd[31:24]);
   endtask

   task route(input logic [3:0] c7, input logic [3:0] c6);
      cfgWrite(gil_pkg::ROUTE_DWORD, 4'hf, {c7, c6, 24'h000000});
      tick(4);
   endtask

   task finish_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog on the whole run
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         failures++;
         finish_test;
      end
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      tick(4);
      rstn = 1;
      ctlRead(8'h80);
      cfgRead(gil_pkg::ROUTE_DWORD, rd);
      check("route reset", 32'h00000000, rd);
      cfgWrite(gil_pkg::ROUTE_DWORD, 4'hf, 32'hffffffff);
      cfgRead(gil_pkg::ROUTE_DWORD, rd);
      check("route all", 32'hffffffff, rd);
      cfgWrite(gil_pkg::ROUTE_DWORD, 4'h5, 32'h00000000);
      cfgRead(gil_pkg::ROUTE_DWORD, rd);
      check("route lanes", 32'hff00ff00, rd);
      $display("test registers done");
      // Output mode drives written value, reserved bits read zero
      cfgWrite(gil_pkg::CTL_DWORD, 4'h8, 32'hff000000);
      tick(3);
      check("gpioOeN", 0, gpioOeN);
      check("gpioOut", 1, gpioOut);
      ctlRead(8'hc3);
      cfgWrite(gil_pkg::CTL_DWORD, 4'h8, 32'hc0000000);
      tick(3);
      ctlRead(8'hc0);
      $display("test output mode done");
      // Input mode change flag and write-one-to-clear
      cfgWrite(gil_pkg::CTL_DWORD, 4'h8, 32'h88000000);
      tick(3);
      check("gpioOeN in", 1, gpioOeN);
      ctlRead(8'h80);
      extLevel = 1;
      tick(3);
      ctlRead(8'h89);
      cfgWrite(gil_pkg::CTL_DWORD, 4'h8, 32'h80000000);
      ctlRead(8'h89);
      cfgWrite(gil_pkg::CTL_DWORD, 4'h8, 32'h88000000);
      ctlRead(8'h81);
      $display("test input mode done");
      // IRQ codes on both pins, parallel scheme on
      parallelIrq = 1;
      for (int k = 2; k < 16; k++)
      begin
         irqLines = 16'h0001 << k;
         route(k[3:0], k[3:0]);
         check("pin7 irq", 1, pin7Out);
         check("pin7OeN", 0, pin7OeN);
         check("pin6 irq", 1, pin6Out);
         irqLines = 16'h0000;
         tick(3);
         check("pin7 low", 0, pin7Out);
         check("pin6 low", 0, pin6Out);
      end
      irqLines = 16'h0002;
      route(4'h2, 4'h1);
      check("pin6 irq1", 1, pin6Out);
      check("pin7 idle", 0, pin7Out);
      parallelIrq = 0;
      tick(3);
      check("pin7 off", 1, pin7OeN);
      $display("test irq routing done");
      // DMA request and grant on pins 7 and 6
      route(4'h0, 4'h0);
      dmaEnable = 1;
      dmaRequest = 1;
      hostLevel = 0;
      tick(4);
      check("pin7 req", 1, pin7Out);
      check("pin6OeN", 1, pin6OeN);
      check("dmaGrant", 0, dmaGrant);
      check("eBlocked", 1, eBlocked);
      dmaRequest = 0;
      tick(3);
      check("pin7 req0", 0, pin7Out);
      dmaEnable = 0;
      dmaRequest = 1;
      route(4'h1, 4'h0);
      check("pin7 code1", 1, pin7Out);
      $display("test dma done");
      // EEPROM lines on code zero with DMA off
      route(4'h0, 4'h0);
      eSclOut = 1;
      eSclOeN = 0;
      tick(3);
      check("scl drive", 0, pin7OeN);
      check("scl level", 1, pin7Out);
      check("sda in", 0, eSdaIn);
      check("grant idle", 1, dmaGrant);
      check("eBlocked0", 0, eBlocked);
      eSclOeN = 1;
      tick(3);
      check("scl release", 1, pin7OeN);
      $display("test eeprom done");
      // INTA mode pulls low on request; reserved mode leaves it free
      cfgWrite(gil_pkg::CTL_DWORD, 4'h8, 32'h00000000);
      intaReq = 1;
      tick(3);
      check("inta drive", 0, gpioOeN);
      check("inta level", 0, gpioOut);
      intaReq = 0;
      tick(3);
      check("inta release", 1, gpioOeN);
      cfgWrite(gil_pkg::CTL_DWORD, 4'h8, 32'h40000000);
      intaReq = 1;
      tick(3);
      check("reserved mode", 1, gpioOeN);
      intaReq = 0;
      $display("test inta mode done");
      // Global reset returns both registers to defaults
      cfgWrite(gil_pkg::CTL_DWORD, 4'h8, 32'hc2000000);
      route(4'h5, 4'h6);
      extLevel = 0;
      rstn = 0;
      tick(2);
      rstn = 1;
      tick(2);
      ctlRead(8'h80);
      cfgRead(gil_pkg::ROUTE_DWORD, rd);
      check("route after", 32'h00000000, rd);
      $display("test global reset done");
      finish_test;
   end
endmodule
